// >>> inc/i2c_master_ctl_pkg.sv
// Shared constants for the two-wire master control and status block
package i2c_master_ctl_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_DEBUG_BEHAVIOR = 6'h02;
  localparam logic [5:0] IDX_MASTER_CONTROL_A = 6'h03;
  localparam logic [5:0] IDX_MASTER_CONTROL_B = 6'h04;
  localparam logic [5:0] IDX_MASTER_FLAGS = 6'h05;
  localparam logic [5:0] IDX_MASTER_TARGET_REG = 6'h07;
  localparam logic [5:0] IDX_MASTER_SHIFT_REG = 6'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_RUN_WHILE_HALTED = 0;
  localparam int BIT_READ_IRQ_EN = 7;
  localparam int BIT_WRITE_IRQ_EN = 6;
  localparam int BIT_QUICK_CMD_EN = 4;
  localparam int BIT_TIMEOUT_LO = 2;
  localparam int BIT_AUTO_ACK_ON_READ = 1;
  localparam int BIT_MASTER_ENABLE = 0;
  localparam int BIT_FLUSH = 3;
  localparam int BIT_ACK_CHOICE = 2;
  localparam int BIT_OP_CODE_LO = 0;
  localparam int BIT_READ_DONE = 7;
  localparam int BIT_WRITE_DONE = 6;
  localparam int BIT_SCL_STRETCH = 5;
  localparam int BIT_LAST_SLAVE_ACK = 4;
  localparam int BIT_LOST_OWNERSHIP = 3;
  localparam int BIT_ILLEGAL_CONDITION = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG8 = 8'h00;

  // ----------------------------------------------------------------
  // Command encodings and time-out selections
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_RESTART = 2'h1;
  localparam logic [1:0] OP_BYTE_XFER = 2'h2;
  localparam logic [1:0] OP_STOP = 2'h3;
  localparam logic [1:0] TO_OFF = 2'h0;
  localparam logic [1:0] TO_SHORT = 2'h1;
  localparam logic [1:0] TO_MID = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TO_SHORT_NS = 50000;
  localparam int TO_MID_NS = 100000;
  localparam int TO_LONG_NS = 200000;
  localparam int TO_SHORT_CYC = TO_SHORT_NS / CLK_PERIOD_NS;
  localparam int TO_MID_CYC = TO_MID_NS / CLK_PERIOD_NS;
  localparam int TO_LONG_CYC = TO_LONG_NS / CLK_PERIOD_NS;

endpackage

// >>> verilog/i2c_master_control_status.sv
// Register file, command strobes and status flags of the two-wire bus master
`timescale 1ns/100ps

module i2c_master_control_status #(
  parameter int TO_CNT_W = 12
) (
  input wire logic i_mclk,            // System clock, 20 MHz
  input wire logic i_reset_n,         // Asynchronous reset, active low
  input wire logic i_psel,            // APB select
  input wire logic i_penable,         // APB enable
  input wire logic i_pwrite,          // APB direction, 1 write
  input wire logic [7:0] i_paddr,     // APB byte address
  input wire logic [31:0] i_pwdata,   // APB write data
  output logic [31:0] o_prdata,       // APB read data
  output logic o_pready,              // APB ready
  output logic o_pslverr,             // APB error, unmapped address
  input wire logic i_cpu_halted,      // Processor stopped in debug break
  input wire logic i_global_irq_en,   // Processor global interrupt enable
  input wire logic i_scl,             // Bus clock line level, asynchronous
  input wire logic i_addr_done,       // Engine: address byte and its ack finished
  input wire logic i_write_done,      // Engine: data byte send and its ack finished
  input wire logic i_read_done,       // Engine: data byte received
  input wire logic [7:0] i_rx_byte,   // Engine: byte received, valid with i_read_done
  input wire logic i_ack_valid,       // Engine: slave acknowledge bit sampled
  input wire logic i_ack_bit,         // Engine: sampled bit, 0 ACK 1 NACK
  input wire logic i_hold_begin,      // Engine: master starts holding clock low
  input wire logic i_lost,            // Engine: arbitration lost
  input wire logic i_illegal,         // Engine: illegal bus condition
  input wire logic [1:0] i_bus_state, // Bus state logic state
  output logic o_master_run,          // Master enabled, not frozen and not flushing
  output logic o_flush,               // One-cycle master flush strobe
  output logic o_quick_cmd,           // Quick command mode
  output logic o_start_addr,          // Strobe: send start and address
  output logic [7:0] o_addr,          // Address byte, bit 0 direction
  output logic o_data_send,           // Strobe: send the data byte
  output logic [7:0] o_data,          // Data byte to send
  output logic o_ack_go,              // Strobe: perform acknowledge action
  output logic o_ack_nack,            // Acknowledge action, 1 NACK
  output logic o_op_restart,          // Strobe: repeated start
  output logic o_op_read,             // Strobe: byte read
  output logic o_op_stop,             // Strobe: stop
  output logic o_bus_to_idle,         // Strobe: time-out forces bus idle
  output logic o_read_irq,            // Master read interrupt request
  output logic o_write_irq            // Master write interrupt request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic run_while_halted;
    logic read_irq_en;
    logic write_irq_en;
    logic quick_cmd_en;
    logic [1:0] timeout_sel;
    logic auto_ack_on_read;
    logic master_en;
    logic ack_choice;
    logic read_done_flag;
    logic write_done_flag;
    logic scl_stretch_flag;
    logic last_slave_ack;
    logic lost_ownership_flag;
    logic illegal_condition_flag;
    logic addr_acked;
    logic [7:0] master_target_reg;
    logic [7:0] master_shift_reg;
    logic flush;
    logic start_addr;
    logic data_send;
    logic ack_go;
    logic op_restart;
    logic op_read;
    logic op_stop;
    logic read_irq;
    logic write_irq;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic [TO_CNT_W-1:0] idle_cnt;
    logic bus_to_idle;
    logic master_run;
  } state_s;

  state_s st_q;
  state_s st_d;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Register access decode, side effects and flag updates; sets are applied
  // after clears so an engine event in a clearing cycle is never lost
  always_comb
  begin
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic hit_ok;
    logic [5:0] idx;
    logic frozen;
    logic act;
    logic wr_ctlb;
    logic wr_addr;
    logic wr_data;
    logic rd_data;
    logic valid_cmd;
    logic [1:0] cmd;
    logic new_ack;
    logic dir_read;
    logic [7:0] rdv;
    logic [TO_CNT_W-1:0] limit;
    setup = 1'b0;
    access = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    hit_ok = 1'b0;
    idx = 6'h00;
    frozen = 1'b0;
    act = 1'b0;
    wr_ctlb = 1'b0;
    wr_addr = 1'b0;
    wr_data = 1'b0;
    rd_data = 1'b0;
    valid_cmd = 1'b0;
    cmd = i2c_master_ctl_pkg::OP_NONE;
    new_ack = 1'b0;
    dir_read = 1'b0;
    rdv = 8'h00;
    limit = '0;
    st_d = st_q;

    // Strobes last one cycle
    st_d.flush = 1'b0;
    st_d.start_addr = 1'b0;
    st_d.data_send = 1'b0;
    st_d.ack_go = 1'b0;
    st_d.op_restart = 1'b0;
    st_d.op_read = 1'b0;
    st_d.op_stop = 1'b0;
    st_d.bus_to_idle = 1'b0;

    // Frozen during a debug break unless told to keep running
    frozen = i_cpu_halted && !st_q.run_while_halted;
    act = st_q.master_en && !frozen;

    // APB: setup cycle prepares answer, access cycle with ready commits
    setup = i_psel && !i_penable;
    access = i_psel && i_penable && st_q.pready;
    idx = i_paddr[7:2];
    hit_ok = (i_paddr[1:0] == 2'h0)
      && (idx == i2c_master_ctl_pkg::IDX_DEBUG_BEHAVIOR || idx == i2c_master_ctl_pkg::IDX_MASTER_CONTROL_A
      || idx == i2c_master_ctl_pkg::IDX_MASTER_CONTROL_B || idx == i2c_master_ctl_pkg::IDX_MASTER_FLAGS
      || idx == i2c_master_ctl_pkg::IDX_MASTER_TARGET_REG || idx == i2c_master_ctl_pkg::IDX_MASTER_SHIFT_REG);
    wr = access && i_pwrite && !st_q.pslverr;
    rd = access && !i_pwrite && !st_q.pslverr;
    st_d.pready = setup;
    if (setup)
    begin
      st_d.pslverr = !hit_ok;
      case (idx)
        i2c_master_ctl_pkg::IDX_DEBUG_BEHAVIOR: rdv = {7'h00, st_q.run_while_halted};
        i2c_master_ctl_pkg::IDX_MASTER_CONTROL_A: rdv = {st_q.read_irq_en, st_q.write_irq_en, 1'b0,
          st_q.quick_cmd_en, st_q.timeout_sel, st_q.auto_ack_on_read, st_q.master_en};
        i2c_master_ctl_pkg::IDX_MASTER_CONTROL_B: rdv = {5'h00, st_q.ack_choice, 2'h0};
        i2c_master_ctl_pkg::IDX_MASTER_FLAGS: rdv = {st_q.read_done_flag, st_q.write_done_flag,
          st_q.scl_stretch_flag, st_q.last_slave_ack, st_q.lost_ownership_flag,
          st_q.illegal_condition_flag, i_bus_state};
        i2c_master_ctl_pkg::IDX_MASTER_TARGET_REG: rdv = st_q.master_target_reg;
        i2c_master_ctl_pkg::IDX_MASTER_SHIFT_REG: rdv = st_q.master_shift_reg;
        default: rdv = 8'h00;
      endcase
      st_d.prdata = {24'h000000, rdv};
    end
    else if (!i_psel)
    begin
      st_d.pslverr = 1'b0;
    end

    // Plain control registers
    if (wr && idx == i2c_master_ctl_pkg::IDX_DEBUG_BEHAVIOR)
    begin
      st_d.run_while_halted = i_pwdata[i2c_master_ctl_pkg::BIT_RUN_WHILE_HALTED];
    end
    if (wr && idx == i2c_master_ctl_pkg::IDX_MASTER_CONTROL_A)
    begin
      st_d.read_irq_en = i_pwdata[i2c_master_ctl_pkg::BIT_READ_IRQ_EN];
      st_d.write_irq_en = i_pwdata[i2c_master_ctl_pkg::BIT_WRITE_IRQ_EN];
      st_d.quick_cmd_en = i_pwdata[i2c_master_ctl_pkg::BIT_QUICK_CMD_EN];
      st_d.timeout_sel = i_pwdata[i2c_master_ctl_pkg::BIT_TIMEOUT_LO +: 2];
      st_d.auto_ack_on_read = i_pwdata[i2c_master_ctl_pkg::BIT_AUTO_ACK_ON_READ];
      st_d.master_en = i_pwdata[i2c_master_ctl_pkg::BIT_MASTER_ENABLE];
    end

    // Control B: acknowledge choice and command in one write
    wr_ctlb = wr && idx == i2c_master_ctl_pkg::IDX_MASTER_CONTROL_B;
    new_ack = wr_ctlb ? i_pwdata[i2c_master_ctl_pkg::BIT_ACK_CHOICE] : st_q.ack_choice;
    cmd = i_pwdata[i2c_master_ctl_pkg::BIT_OP_CODE_LO +: 2];
    st_d.ack_choice = new_ack;
    valid_cmd = wr_ctlb && act && cmd != i2c_master_ctl_pkg::OP_NONE;
    dir_read = st_q.master_target_reg[0];
    if (valid_cmd)
    begin
      // The acknowledge value driven out is the one written with this command
      st_d.ack_go = !(cmd == i2c_master_ctl_pkg::OP_BYTE_XFER && !dir_read);
      st_d.op_restart = cmd == i2c_master_ctl_pkg::OP_RESTART;
      st_d.op_read = cmd == i2c_master_ctl_pkg::OP_BYTE_XFER && dir_read;
      st_d.data_send = cmd == i2c_master_ctl_pkg::OP_BYTE_XFER && !dir_read;
      st_d.op_stop = cmd == i2c_master_ctl_pkg::OP_STOP;
    end

    // Address and data register accesses
    wr_addr = wr && idx == i2c_master_ctl_pkg::IDX_MASTER_TARGET_REG;
    wr_data = wr && idx == i2c_master_ctl_pkg::IDX_MASTER_SHIFT_REG;
    rd_data = rd && idx == i2c_master_ctl_pkg::IDX_MASTER_SHIFT_REG;
    if (wr_addr)
    begin
      st_d.master_target_reg = i_pwdata[7:0];
      st_d.start_addr = act;
      st_d.addr_acked = 1'b0;
    end
    if (wr_data)
    begin
      st_d.master_shift_reg = i_pwdata[7:0];
      st_d.data_send = act;
    end
    // Smart mode only acts on a read while the choice is ACK, so a NACKed
    // read never triggers another byte
    if (rd_data && act && st_q.auto_ack_on_read && !st_q.ack_choice && dir_read)
    begin
      st_d.ack_go = 1'b1;
      st_d.op_read = 1'b1;
    end

    // Flag clears by software access
    if (wr && idx == i2c_master_ctl_pkg::IDX_MASTER_FLAGS)
    begin
      if (i_pwdata[i2c_master_ctl_pkg::BIT_READ_DONE]) st_d.read_done_flag = 1'b0;
      if (i_pwdata[i2c_master_ctl_pkg::BIT_WRITE_DONE]) st_d.write_done_flag = 1'b0;
      if (i_pwdata[i2c_master_ctl_pkg::BIT_SCL_STRETCH]) st_d.scl_stretch_flag = 1'b0;
      if (i_pwdata[i2c_master_ctl_pkg::BIT_LOST_OWNERSHIP]) st_d.lost_ownership_flag = 1'b0;
      if (i_pwdata[i2c_master_ctl_pkg::BIT_ILLEGAL_CONDITION]) st_d.illegal_condition_flag = 1'b0;
    end
    if (wr_data || rd_data || valid_cmd)
    begin
      st_d.read_done_flag = 1'b0;
      st_d.write_done_flag = 1'b0;
      st_d.scl_stretch_flag = 1'b0;
    end
    if (wr_addr)
    begin
      st_d.read_done_flag = 1'b0;
      st_d.write_done_flag = 1'b0;
      st_d.scl_stretch_flag = 1'b0;
      st_d.lost_ownership_flag = 1'b0;
      st_d.illegal_condition_flag = 1'b0;
    end

    // Flush wipes address, data, done and stretch flags, address ack and command strobes, but keeps configuration and the lost and illegal flags
    if (wr_ctlb && i_pwdata[i2c_master_ctl_pkg::BIT_FLUSH])
    begin
      st_d.flush = 1'b1;
      st_d.master_target_reg = i2c_master_ctl_pkg::RST_REG8;
      st_d.master_shift_reg = i2c_master_ctl_pkg::RST_REG8;
      st_d.read_done_flag = 1'b0;
      st_d.write_done_flag = 1'b0;
      st_d.scl_stretch_flag = 1'b0;
      st_d.addr_acked = 1'b0;
      st_d.start_addr = 1'b0;
      st_d.data_send = 1'b0;
      st_d.ack_go = 1'b0;
      st_d.op_restart = 1'b0;
      st_d.op_read = 1'b0;
      st_d.op_stop = 1'b0;
    end

    // Engine events set flags; ignored while frozen or disabled
    if (act)
    begin
      if (i_lost) st_d.lost_ownership_flag = 1'b1;
      if (i_illegal) st_d.illegal_condition_flag = 1'b1;
      if (i_ack_valid) st_d.last_slave_ack = i_ack_bit;
      if (i_hold_begin) st_d.scl_stretch_flag = 1'b1;
      if (i_addr_done && i_ack_valid && !i_ack_bit) st_d.addr_acked = 1'b1;
      if (i_write_done || (i_addr_done && !(st_q.quick_cmd_en && dir_read))) st_d.write_done_flag = 1'b1;
      // Quick command raises the flag for the direction as soon as the address is acked
      if (i_addr_done && st_q.quick_cmd_en && dir_read && i_ack_valid && !i_ack_bit)
        st_d.read_done_flag = 1'b1;
      if (i_addr_done && st_q.quick_cmd_en && dir_read && !(i_ack_valid && !i_ack_bit))
        st_d.write_done_flag = 1'b1;
      if (i_read_done && st_q.addr_acked && !i_lost && !i_illegal
        && !st_q.lost_ownership_flag && !st_q.illegal_condition_flag)
      begin
        st_d.read_done_flag = 1'b1;
        st_d.master_shift_reg = i_rx_byte;
      end
    end

    // Run level is registered so the port comes from a flop; it drops while
    // frozen by a debug break and for the flush cycle
    st_d.master_run = st_d.master_en && !(i_cpu_halted && !st_d.run_while_halted) && !st_d.flush;

    // Interrupt requests from the next flag values
    st_d.read_irq = st_d.read_irq_en && st_d.read_done_flag && i_global_irq_en;
    st_d.write_irq = st_d.write_irq_en && st_d.write_done_flag && i_global_irq_en;

    // Inactivity supervisor: any clock-line edge restarts the count; the
    // figures assume a 100 kHz bus and do not scale with the baud setting
    st_d.scl_s1 = i_scl;
    st_d.scl_s2 = st_q.scl_s1;
    st_d.scl_s3 = st_q.scl_s2;
    case (st_q.timeout_sel)
      i2c_master_ctl_pkg::TO_SHORT: limit = TO_CNT_W'(i2c_master_ctl_pkg::TO_SHORT_CYC);
      i2c_master_ctl_pkg::TO_MID: limit = TO_CNT_W'(i2c_master_ctl_pkg::TO_MID_CYC);
      default: limit = TO_CNT_W'(i2c_master_ctl_pkg::TO_LONG_CYC);
    endcase
    if (st_q.timeout_sel == i2c_master_ctl_pkg::TO_OFF || !act || (st_q.scl_s2 != st_q.scl_s3))
    begin
      st_d.idle_cnt = '0;
    end
    else if (st_q.idle_cnt != limit)
    begin
      st_d.idle_cnt = st_q.idle_cnt + TO_CNT_W'(1);
      st_d.bus_to_idle = (st_q.idle_cnt + TO_CNT_W'(1)) == limit;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything clears to zero on reset
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All straight from flops
  assign o_prdata = st_q.prdata;
  assign o_pready = st_q.pready;
  assign o_pslverr = st_q.pslverr;
  assign o_master_run = st_q.master_run;
  assign o_flush = st_q.flush;
  assign o_quick_cmd = st_q.quick_cmd_en;
  assign o_start_addr = st_q.start_addr;
  assign o_addr = st_q.master_target_reg;
  assign o_data_send = st_q.data_send;
  assign o_data = st_q.master_shift_reg;
  assign o_ack_go = st_q.ack_go;
  assign o_ack_nack = st_q.ack_choice;
  assign o_op_restart = st_q.op_restart;
  assign o_op_read = st_q.op_read;
  assign o_op_stop = st_q.op_stop;
  assign o_bus_to_idle = st_q.bus_to_idle;
  assign o_read_irq = st_q.read_irq;
  assign o_write_irq = st_q.write_irq;

endmodule

// >>> test/i2c_master_ctl_sva.sv
// Concurrent checks on the ports of the master control and status block
`timescale 1ns/100ps
module i2c_master_ctl_sva (
  input wire logic i_mclk,          // Clock
  input wire logic i_reset_n,       // Reset
  input wire logic i_psel,          // Select
  input wire logic i_penable,       // Enable
  input wire logic i_pwrite,        // Write
  input wire logic [7:0] i_paddr,   // Address
  input wire logic [31:0] i_pwdata, // Write data
  input wire logic i_global_irq_en, // Global irq
  input wire logic [31:0] o_prdata, // Read data
  input wire logic o_pready,        // Ready
  input wire logic o_master_run,    // Running
  input wire logic o_flush,         // Flush
  input wire logic o_start_addr,    // Address go
  input wire logic [7:0] o_addr,    // Address
  input wire logic o_data_send,     // Send
  input wire logic o_ack_go,        // Ack go
  input wire logic o_ack_nack,      // Ack choice
  input wire logic o_op_restart,    // Restart
  input wire logic o_op_read,       // Read
  input wire logic o_op_stop,       // Stop
  input wire logic o_read_irq,      // Read irq
  input wire logic o_write_irq      // Write irq
);
  // ----------------------------------------
  // Committed writes; strobes land next cycle
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  wire wr = i_psel && i_penable && o_pready && i_pwrite;
  // Flush is kept out so that a combined write cannot mask a command
  wire cmd = wr && o_master_run && i_paddr == 8'h10 && !i_pwdata[3];
  cmd_readback_a: assert property (o_pready && !i_pwrite && i_paddr == 8'h10 |-> (o_prdata[3:0] & 4'hb) == 4'h0)
    else $error("command or flush bit read back set");
  flush_pulse_a: assert property (wr && i_paddr == 8'h10 && i_pwdata[3] |=> o_flush && !o_master_run ##1 !o_flush)
    else $error("flush strobe not one cycle");
  stop_op_a: assert property (cmd && i_pwdata[1:0] == 2'h3 |=> o_op_stop && o_ack_go && o_ack_nack == $past(i_pwdata[2]))
    else $error("stop command strobes wrong");
  restart_op_a: assert property (cmd && i_pwdata[1:0] == 2'h1 |=> o_op_restart && o_ack_go && !o_op_stop)
    else $error("restart command strobes wrong");
  byte_op_a: assert property (cmd && i_pwdata[1:0] == 2'h2 |=> o_op_read == o_addr[0] && o_data_send == !o_addr[0])
    else $error("byte command ignores direction");
  no_op_a: assert property (cmd && i_pwdata[1:0] == 2'h0 |=> !o_ack_go && !o_op_restart && !o_op_read && !o_op_stop)
    else $error("idle command caused a strobe");
  addr_go_a: assert property (wr && o_master_run && i_paddr == 8'h1c |=> o_start_addr && o_addr == $past(i_pwdata[7:0]))
    else $error("address write did not start");
  irq_gate_a: assert property (!i_global_irq_en |=> !o_read_irq && !o_write_irq)
    else $error("interrupt raised with global enable off");
endmodule

bind i2c_master_control_status i2c_master_ctl_sva u_sva (.*);

// >>> test/twi_engine_model.sv
// Behavioural bus engine and slave answering the master's strobes
`timescale 1ns/100ps
module twi_engine_model #(
  parameter int DLY = 8,
  parameter logic [7:0] RX = 8'h3c
) (
  input wire logic i_mclk,        // Clock
  input wire logic i_reset_n,     // Reset
  input wire logic i_start,       // Address strobe
  input wire logic i_dir,         // Address bit 0, 1 read
  input wire logic i_send,        // Send strobe
  input wire logic i_read,        // Read strobe
  input wire logic i_nack,        // Slave answers NACK
  output logic o_addr_done,       // Address finished
  output logic o_write_done,      // Send finished
  output logic o_read_done,       // Byte received
  output logic [7:0] o_rx,        // Received byte
  output logic o_ack_valid,       // Ack sampled
  output logic o_ack_bit,         // Ack bit
  output logic o_hold             // Clock held low
);
  logic [3:0] cnt;
  logic [1:0] kind;
  // Each strobe answers after DLY cycles; kind 1 address, 2 send, 3 read
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      cnt <= 4'h0;
      kind <= 2'h0;
    end
    else if (i_start || i_send || i_read)
    begin
      cnt <= 4'(DLY);
      kind <= i_start ? 2'h1 : (i_send ? 2'h2 : 2'h3);
    end
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (kind == 2'h1 && i_dir && !i_nack)
    begin
      // A byte is read only after the address was acknowledged
      cnt <= 4'(DLY);
      kind <= 2'h3;
    end
    else
      kind <= 2'h0;
  // Pulses; the byte lines are not valid outside the read pulse
  assign o_addr_done = cnt == 4'h1 && kind == 2'h1;
  assign o_write_done = cnt == 4'h1 && kind == 2'h2;
  assign o_read_done = cnt == 4'h1 && kind == 2'h3;
  assign o_rx = o_read_done ? RX : ~RX;
  assign o_ack_valid = o_addr_done || o_write_done;
  assign o_ack_bit = i_nack;
  assign o_hold = cnt == 4'h1 && !i_nack;
endmodule

// >>> test/i2c_master_control_status_tb.sv
// Self-checking bench for the master control and status block
`timescale 1ns/100ps
module i2c_master_control_status_tb;
  logic i_mclk = 0, i_reset_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, o_pready, o_pslverr, err;
  logic i_cpu_halted = 0, i_global_irq_en = 1, i_scl = 0, i_lost = 0, i_illegal = 0, scl_run = 1, nack = 0;
  logic [7:0] i_paddr = 8'h00, o_addr, o_data, i_rx_byte;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q;
  logic [1:0] i_bus_state = 2'h2;
  logic o_master_run, o_flush, o_quick_cmd, o_start_addr, o_data_send, o_ack_go, o_ack_nack, o_op_restart;
  logic o_op_read, o_op_stop, o_bus_to_idle, o_read_irq, o_write_irq;
  logic i_addr_done, i_write_done, i_read_done, i_ack_valid, i_ack_bit, i_hold_begin;
  int n_errors = 0, tests_run = 0, cyc = 0, n_rd = 0, k, n;
  i2c_master_control_status u_dut (.*);
  twi_engine_model u_eng (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_start(o_start_addr), .i_dir(o_addr[0]),
    .i_send(o_data_send), .i_read(o_op_read), .i_nack(nack), .o_addr_done(i_addr_done), .o_write_done(i_write_done),
    .o_read_done(i_read_done), .o_rx(i_rx_byte), .o_ack_valid(i_ack_valid), .o_ack_bit(i_ack_bit), .o_hold(i_hold_begin));
  // -----------------------------
  // Clocks, run limit, read count
  // -----------------------------
  always #25 i_mclk = ~i_mclk;
  always #200 if (scl_run) i_scl = ~i_scl;
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    n_rd <= n_rd + int'(o_op_read);
    if (cyc == 30000)
    begin
      n_errors++;
      wrap_up;
    end
  end
  // One transfer; returns half a cycle after the commit edge so strobes are settled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    q = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ------------------------
  // Test sequence
  // ------------------------
  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    for (k = 2; k < 6; k++)
      rd(8'(k * 4), (k == 5) ? 32'h2 : 32'h0);
    rd(8'h04, 32'h0);
    chk(err, 1'b1);
    $display("done: reset values");
    apb(1'b1, 8'h0c, 32'hd3);
    rd(8'h0c, 32'hd3);
    chk(o_master_run, 1'b1);
    @(posedge i_mclk);
    i_cpu_halted <= 1'b1;
    repeat (2) @(negedge i_mclk);
    chk(o_master_run, 1'b0);
    apb(1'b1, 8'h08, 32'h1);
    chk(o_master_run, 1'b1);
    @(posedge i_mclk);
    i_cpu_halted <= 1'b0;
    $display("done: enable and halt");
    // Write address acknowledged: write flag, clock held, bus state shown
    apb(1'b1, 8'h1c, 32'ha0);
    repeat (12) @(negedge i_mclk);
    rd(8'h14, 32'h62);
    chk(o_write_irq, 1'b1);
    @(posedge i_mclk);
    i_global_irq_en <= 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(o_write_irq, 1'b0);
    @(posedge i_mclk);
    i_global_irq_en <= 1'b1;
    apb(1'b1, 8'h14, 32'h40);
    rd(8'h14, 32'h22);
    apb(1'b1, 8'h14, 32'h20);
    rd(8'h14, 32'h02);
    $display("done: address and flag clearing");
    // Slave refuses a data byte, then stop with NACK choice in the same write
    nack = 1'b1;
    apb(1'b1, 8'h20, 32'h5a);
    repeat (12) @(negedge i_mclk);
    rd(8'h14, 32'h52);
    apb(1'b1, 8'h10, 32'h07);
    rd(8'h10, 32'h04);
    rd(8'h14, 32'h12);
    nack = 1'b0;
    $display("done: refused byte and stop");
    // Read direction; smart mode reads the byte and asks for the next one
    apb(1'b1, 8'h10, 32'h00);
    apb(1'b1, 8'h1c, 32'ha1);
    repeat (24) @(negedge i_mclk);
    rd(8'h14, 32'ha2);
    chk(o_read_irq, 1'b1);
    k = n_rd;
    rd(8'h20, 32'h3c);
    repeat (2) @(negedge i_mclk);
    chk(32'(n_rd - k), 32'h1);
    for (k = 0; k < 4; k++)
      apb(1'b1, 8'h10, 32'(k));
    apb(1'b1, 8'h1c, 32'ha0);
    apb(1'b1, 8'h10, 32'h02);
    $display("done: read direction and commands");
    // Lost ownership and illegal condition are wiped by an address write
    repeat (20) @(posedge i_mclk);
    i_lost <= 1'b1;
    i_illegal <= 1'b1;
    @(posedge i_mclk);
    i_lost <= 1'b0;
    i_illegal <= 1'b0;
    rd(8'h14, 32'h6e);
    apb(1'b1, 8'h1c, 32'ha0);
    apb(1'b0, 8'h14, 32'h0);
    chk(q[7:2], 6'h0);
    // Data before address leaves junk; flush wipes both registers
    repeat (20) @(posedge i_mclk);
    apb(1'b1, 8'h20, 32'h99);
    apb(1'b1, 8'h10, 32'h08);
    rd(8'h1c, 32'h0);
    chk(o_data, 8'h00);
    $display("done: lost, illegal and flush");
    // Stopped clock line: short, mid and long time-out selections, each from its own last edge
    for (k = 1; k < 4; k++)
    begin
      scl_run = 1'b0;
      apb(1'b1, 8'h0c, 32'(k * 4 + 1));
      @(posedge i_mclk);
      i_scl <= ~i_scl;
      n = 0;
      do @(negedge i_mclk) n++; while (o_bus_to_idle !== 1'b1 && n < 5000);
      chk(n >= (500 << k) - 2 && n <= (500 << k) + 6, 1'b1);
      scl_run = 1'b1;
      repeat (20) @(posedge i_mclk);
    end
    $display("done: time-out");
    wrap_up;
  end
endmodule
